// >>> rrh_exec_unit.sv
/*
  Execution unit for return, return-with-literal, rotate-right-through-carry,
  halt, literal-minus-accumulator and literal-xor-accumulator.
  Assumes an AXI4-Lite master that loads an opcode into the instruction
  register to run it; one clock, asynchronous active-high reset.
*/
// Behaviour
// - return-with-literal loads its 8-bit literal (0..255) into the accumulator and changes no flag.
// - return-with-literal reloads the pc from the stack top and takes two cycles.
// - plain return pops the stack into the pc, changes no flag and takes two cycles.
// - rotate-right shifts file register 0..127 right through carry, touching only carry.
// - rotate-right writes the accumulator when the destination bit is 0, else the file register.
// - halt clears the watchdog counter and its prescaler to zero.
// - halt clears the power-down flag and sets the timeout flag, nothing else.
// - after halt the oscillator stops and no further instruction runs until the control register is written with the wake bit set.
// - literal-minus-acc puts literal minus accumulator into the accumulator and sets carry, half-carry, zero.
// - literal-xor-acc puts accumulator xor literal into the accumulator and updates only zero.
`timescale 1ns/1ns
module rrh_exec_unit
  import rrh_pkg::*;
#(
  parameter int STACK_DEPTH = 8,
  parameter int WD_PRE_W    = 8,
  parameter int WD_CNT_W    = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // register bus
  input  wire rrh_axi_req_t axi_req,
  output rrh_axi_rsp_t      axi_rsp,
  // core state
  output logic              osc_stopped
);

  localparam int SPW = $clog2(STACK_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rrh_state_t        state_q;
  rrh_axi_rsp_t      rsp_q;
  logic [7:0]        aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic [13:0]       ir_q;
  logic [7:0]        acc_q;
  logic [4:0]        stat_q;
  logic [12:0]       pc_q;
  logic [6:0]        faddr_q;
  logic [7:0]        file_q [128];
  logic [12:0]       stack_q [STACK_DEPTH];
  logic [SPW-1:0]    sp_q;
  logic [WD_CNT_W-1:0] wd_cnt_q;
  logic [WD_PRE_W-1:0] wd_pre_q;
  logic              osc_stop_q;

  // ----------------------------------------------------------------
  // decode and datapath
  // ----------------------------------------------------------------
  function automatic rrh_op_t decode(logic [13:0] i);
    if ((i & OPC_RET_LIT_MASK) == OPC_RET_LIT_MATCH) return OP_RETURN_WITH_LITERAL;
    if ((i & OPC_RET_MASK) == OPC_RET_MATCH) return OP_RETURN;
    if ((i & OPC_ROT_R_MASK) == OPC_ROT_R_MATCH) return OP_ROTATE_RIGHT_CARRY;
    if ((i & OPC_HALT_MASK) == OPC_HALT_MATCH) return OP_HALT;
    if ((i & OPC_LIT_SUB_MASK) == OPC_LIT_SUB_MATCH) return OP_LITERAL_MINUS_ACC;
    if ((i & OPC_LIT_XOR_MASK) == OPC_LIT_XOR_MATCH) return OP_LITERAL_XOR_ACC;
    return OP_OTHER;
  endfunction

  rrh_op_t        op;
  logic           exec;
  logic           idle;
  logic           is_ret;
  logic [7:0]     lit;
  logic [7:0]     fval;
  logic [7:0]     rot;
  logic [8:0]     diff;
  logic [4:0]     hdiff;
  logic [7:0]     xres;
  logic [SPW-1:0] sp_top;

  assign op     = decode(ir_q);
  assign exec   = (state_q == S_EXEC);
  assign idle   = (state_q == S_IDLE);
  assign is_ret = (op == OP_RETURN_WITH_LITERAL) || (op == OP_RETURN);
  assign lit    = ir_q[7:0];
  assign fval   = file_q[ir_q[6:0]];
  assign rot    = {stat_q[ST_CARRY], fval[7:1]};
  assign diff   = {1'b0, lit} + {1'b0, ~acc_q} + 9'h001;
  assign hdiff  = {1'b0, lit[3:0]} + {1'b0, ~acc_q[3:0]} + 5'h01;
  assign xres   = acc_q ^ lit;
  assign sp_top = sp_q - 1'b1;

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  logic        wr_fire;
  logic        wr_ok;
  logic [15:0] wmask;

  function automatic logic mapped(logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_CTRL);
  endfunction

  assign wr_fire = !rsp_q.awready && !rsp_q.wready && !rsp_q.bvalid;
  assign wr_ok   = wr_fire && mapped(aw_addr_q) && aw_addr_q != ADDR_WATCHDOG &&
                   (idle || aw_addr_q == ADDR_CTRL);
  assign wmask   = {{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  function automatic logic hit(logic [7:0] a);
    return wr_ok && (aw_addr_q == a);
  endfunction

  function automatic logic [15:0] put(logic [15:0] o);
    return (o & ~wmask) | (w_data_q[15:0] & wmask);
  endfunction

  function automatic logic [31:0] rd(logic [7:0] a);
    case (a)
      ADDR_INSTR:    rd = {18'h0, ir_q};
      ADDR_ACC:      rd = {24'h0, acc_q};
      ADDR_STATUS:   rd = {27'h0, stat_q};
      ADDR_PC:       rd = {19'h0, pc_q};
      ADDR_FADDR:    rd = {25'h0, faddr_q};
      ADDR_FDATA:    rd = {24'h0, file_q[faddr_q]};
      ADDR_STACK:    rd = {19'h0, stack_q[sp_top]};
      ADDR_WATCHDOG: rd = 32'({wd_pre_q, wd_cnt_q});
      ADDR_CTRL:     rd = {30'h0, osc_stop_q, !idle};
      default:       rd = 32'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // axi4-lite channels
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q     <= RSP_RESET;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0;
      w_strb_q  <= 4'h0;
    end else begin
      if (axi_req.awvalid && rsp_q.awready) begin
        rsp_q.awready <= 1'b0;
        aw_addr_q     <= axi_req.awaddr;
      end
      if (axi_req.wvalid && rsp_q.wready) begin
        rsp_q.wready <= 1'b0;
        w_data_q     <= axi_req.wdata;
        w_strb_q     <= axi_req.wstrb;
      end
      if (wr_fire) begin
        rsp_q.bvalid <= 1'b1;
        rsp_q.bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rsp_q.bvalid && axi_req.bready) begin
        rsp_q.bvalid  <= 1'b0;
        rsp_q.awready <= 1'b1;
        rsp_q.wready  <= 1'b1;
      end
      if (axi_req.arvalid && rsp_q.arready) begin
        rsp_q.arready <= 1'b0;
        rsp_q.rvalid  <= 1'b1;
        rsp_q.rdata   <= rd(axi_req.araddr);
        rsp_q.rresp   <= mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rsp_q.rvalid && axi_req.rready) begin
        rsp_q.rvalid  <= 1'b0;
        rsp_q.arready <= 1'b1;
      end
    end
  end

  assign axi_rsp     = rsp_q;
  assign osc_stopped = osc_stop_q;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (hit(ADDR_INSTR)) state_q <= S_EXEC;
        end
        S_EXEC: begin
          if (is_ret) state_q <= S_SECOND;
          else if (op == OP_HALT) state_q <= S_HALT;
          else state_q <= S_IDLE;
        end
        S_SECOND: state_q <= S_IDLE;
        S_HALT: begin
          if (hit(ADDR_CTRL) && w_data_q[CTRL_WAKE]) state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) osc_stop_q <= 1'b0;
    else if (exec && op == OP_HALT) osc_stop_q <= 1'b1;
    else if (hit(ADDR_CTRL) && w_data_q[CTRL_WAKE]) osc_stop_q <= 1'b0;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) ir_q <= 14'h0;
    else if (idle && hit(ADDR_INSTR)) ir_q <= 14'(put({2'h0, ir_q}));
  end

  // ----------------------------------------------------------------
  // accumulator and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= 8'h00;
    end else if (exec) begin
      case (op)
        OP_RETURN_WITH_LITERAL: acc_q <= lit;
        OP_LITERAL_MINUS_ACC:   acc_q <= diff[7:0];
        OP_LITERAL_XOR_ACC:     acc_q <= xres;
        OP_ROTATE_RIGHT_CARRY:  if (!ir_q[DEST_BIT]) acc_q <= rot;
        default: ;
      endcase
    end else if (hit(ADDR_ACC)) begin
      acc_q <= 8'(put({8'h0, acc_q}));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= STATUS_RESET;
    end else if (exec) begin
      case (op)
        OP_ROTATE_RIGHT_CARRY: stat_q[ST_CARRY] <= fval[0];
        OP_LITERAL_MINUS_ACC: begin
          stat_q[ST_CARRY] <= diff[8];
          stat_q[ST_HALF]  <= hdiff[4];
          stat_q[ST_ZERO]  <= (diff[7:0] == 8'h00);
        end
        OP_LITERAL_XOR_ACC: stat_q[ST_ZERO] <= (xres == 8'h00);
        OP_HALT: begin
          stat_q[ST_PDOWN_N]   <= 1'b0;
          stat_q[ST_TIMEOUT_N] <= 1'b1;
        end
        default: ;
      endcase
    end else if (hit(ADDR_STATUS)) begin
      stat_q <= 5'(put({11'h0, stat_q}));
    end
  end

  // ----------------------------------------------------------------
  // program counter and return stack
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) pc_q <= 13'h0;
    else if (exec && is_ret) pc_q <= stack_q[sp_top];
    else if (exec) pc_q <= pc_q + 13'h1;
    else if (hit(ADDR_PC)) pc_q <= 13'(put({3'h0, pc_q}));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) sp_q <= '0;
    else if (exec && is_ret) sp_q <= sp_top;
    else if (hit(ADDR_STACK)) sp_q <= sp_q + 1'b1;
  end

  always_ff @(posedge clk) begin
    if (hit(ADDR_STACK)) stack_q[sp_q] <= 13'(put(16'h0));
  end

  // ----------------------------------------------------------------
  // file registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) faddr_q <= 7'h00;
    else if (hit(ADDR_FADDR)) faddr_q <= 7'(put({9'h0, faddr_q}));
  end

  always_ff @(posedge clk) begin
    if (exec && op == OP_ROTATE_RIGHT_CARRY && ir_q[DEST_BIT]) file_q[ir_q[6:0]] <= rot;
    else if (hit(ADDR_FDATA)) file_q[faddr_q] <= 8'(put({8'h0, file_q[faddr_q]}));
  end

  // ----------------------------------------------------------------
  // watchdog counter and prescaler
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wd_pre_q <= '0;
      wd_cnt_q <= '0;
    end else if (exec && op == OP_HALT) begin
      wd_pre_q <= '0;
      wd_cnt_q <= '0;
    end else if (!osc_stop_q) begin
      wd_pre_q <= wd_pre_q + 1'b1;
      if (&wd_pre_q) wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ret_start;
    exec && is_ret;
  endsequence

  sequence s_ret_end;
    state_q == S_SECOND ##1 state_q == S_IDLE;
  endsequence

  AST_RET_LIT_ACC: assert property (exec && op == OP_RETURN_WITH_LITERAL |=>
    acc_q == $past(lit) && stat_q == $past(stat_q)) else $error("literal return acc or flags wrong");

  AST_RET_TWO_CYCLES: assert property (s_ret_start |=> s_ret_end)
    else $error("return did not take two cycles");

  AST_RET_POP: assert property (s_ret_start |=>
    pc_q == $past(stack_q[sp_top]) && sp_q == $past(sp_top) && stat_q == $past(stat_q))
    else $error("return pop wrong");

  AST_ROT_CARRY: assert property (exec && op == OP_ROTATE_RIGHT_CARRY |=>
    stat_q[ST_CARRY] == $past(fval[0]) && stat_q[4:1] == $past(stat_q[4:1])) else $error("rotate carry wrong");

  AST_ROT_DEST: assert property (exec && op == OP_ROTATE_RIGHT_CARRY |=>
    ($past(ir_q[DEST_BIT]) ? acc_q == $past(acc_q) : acc_q == $past(rot))) else $error("rotate destination wrong");

  AST_HALT_WATCHDOG: assert property (exec && op == OP_HALT |=>
    wd_cnt_q == '0 && wd_pre_q == '0 ##1 wd_pre_q == '0) else $error("watchdog not cleared");

  AST_HALT_FLAGS: assert property (exec && op == OP_HALT |=>
    !stat_q[ST_PDOWN_N] && stat_q[ST_TIMEOUT_N] && stat_q[2:0] == $past(stat_q[2:0])) else $error("halt flags wrong");

  AST_HALT_STOPS: assert property (state_q == S_HALT |=>
    osc_stop_q == (state_q == S_HALT) && $stable(acc_q) && $stable(pc_q) && !exec)
    else $error("instruction ran while halted");

  AST_MINUS: assert property (exec && op == OP_LITERAL_MINUS_ACC |=>
    acc_q == 8'($past(lit) - $past(acc_q)) && stat_q[ST_CARRY] == ($past(lit) >= $past(acc_q)) &&
    stat_q[ST_HALF] == ($past(lit[3:0]) >= $past(acc_q[3:0])) && stat_q[ST_ZERO] == (acc_q == 8'h00))
    else $error("literal minus acc wrong");

  AST_XOR: assert property (exec && op == OP_LITERAL_XOR_ACC |=>
    acc_q == $past(xres) && stat_q[ST_ZERO] == (acc_q == 8'h00) && stat_q[1:0] == $past(stat_q[1:0]))
    else $error("literal xor wrong");

endmodule

// >>> rrh_pkg.sv
/*
  Package of the return/rotate/halt/literal execution unit: register map,
  field positions, reset values, opcode patterns, state and bus carriers.
  Assumes a 32-bit AXI4-Lite register bus with 8 address bits.
*/
package rrh_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR    = 8'h00;
  localparam logic [7:0] ADDR_ACC      = 8'h04;
  localparam logic [7:0] ADDR_STATUS   = 8'h08;
  localparam logic [7:0] ADDR_PC       = 8'h0C;
  localparam logic [7:0] ADDR_FADDR    = 8'h10;
  localparam logic [7:0] ADDR_FDATA    = 8'h14;
  localparam logic [7:0] ADDR_STACK    = 8'h18;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h1C;
  localparam logic [7:0] ADDR_CTRL     = 8'h20;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // status fields and reset values
  // ----------------------------------------------------------------
  localparam int         ST_CARRY     = 0;
  localparam int         ST_HALF      = 1;
  localparam int         ST_ZERO      = 2;
  localparam int         ST_PDOWN_N   = 3;
  localparam int         ST_TIMEOUT_N = 4;
  localparam logic [4:0] STATUS_RESET = 5'h18;
  localparam int         CTRL_WAKE    = 0;
  localparam int         CTRL_HALTED  = 1;
  localparam int         DEST_BIT     = 7;

  // ----------------------------------------------------------------
  // opcode patterns (14-bit words)
  // ----------------------------------------------------------------
  localparam logic [13:0] OPC_RET_LIT_MASK  = 14'h3C00;
  localparam logic [13:0] OPC_RET_LIT_MATCH = 14'h3400;
  localparam logic [13:0] OPC_RET_MASK      = 14'h3FFF;
  localparam logic [13:0] OPC_RET_MATCH     = 14'h0008;
  localparam logic [13:0] OPC_ROT_R_MASK    = 14'h3F00;
  localparam logic [13:0] OPC_ROT_R_MATCH   = 14'h0C00;
  localparam logic [13:0] OPC_HALT_MASK     = 14'h3FFF;
  localparam logic [13:0] OPC_HALT_MATCH    = 14'h0063;
  localparam logic [13:0] OPC_LIT_SUB_MASK  = 14'h3E00;
  localparam logic [13:0] OPC_LIT_SUB_MATCH = 14'h3C00;
  localparam logic [13:0] OPC_LIT_XOR_MASK  = 14'h3F00;
  localparam logic [13:0] OPC_LIT_XOR_MATCH = 14'h3A00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_OTHER, OP_RETURN_WITH_LITERAL, OP_RETURN, OP_ROTATE_RIGHT_CARRY,
    OP_HALT, OP_LITERAL_MINUS_ACC, OP_LITERAL_XOR_ACC
  } rrh_op_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1, S_EXEC = 4'h2, S_SECOND = 4'h4, S_HALT = 4'h8
  } rrh_state_t;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } rrh_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rrh_axi_rsp_t;

  localparam rrh_axi_rsp_t RSP_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

endpackage

// >>> tb_rrh_exec_unit.sv
/*
  Self-checking testbench of the return/rotate/halt/literal execution unit.
  Assumes the unit alone on one 20 MHz clock, driven over AXI4-Lite by the
  tasks below; a queue-based model gives every expected value.
*/
`timescale 1ns/1ns
module tb_rrh_exec_unit;
  import rrh_pkg::*;

  // ----------------------------------------------------------------
  // clock, reset, dut
  // ----------------------------------------------------------------
  logic         clk;
  logic         rst;
  rrh_axi_req_t req;
  rrh_axi_rsp_t rsp;
  logic         osc_stopped;
  int           miscompares;
  int           checked;
  logic [31:0]  acc;
  logic [31:0]  st;
  logic [31:0]  pc;
  logic [31:0]  stk[$];

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  rrh_exec_unit u_rrh_exec_unit (
    .clk         (clk),
    .rst         (rst),
    .axi_req     (req),
    .axi_rsp     (rsp),
    .osc_stopped (osc_stopped)
  );

  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  task automatic cmp_data(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t resp got=%0h exp=%0h", $time, g, e);
    end
  endtask

  task automatic complete_run;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    cmp_resp(r, RESP_OKAY);
  endtask

  task automatic rd_cmp(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axr(a, d, r);
    cmp_resp(r, RESP_OKAY);
    cmp_data(d, e);
  endtask

  // ----------------------------------------------------------------
  // model helpers
  // ----------------------------------------------------------------
  task automatic set_state(input logic [31:0] a, input logic [31:0] s);
    acc = a & 32'h0000_00FF;
    st  = s & 32'h0000_001F;
    wr(ADDR_ACC, acc);
    wr(ADDR_STATUS, st);
  endtask

  task automatic push(input logic [31:0] v);
    stk.push_back(v & 32'h0000_1FFF);
    wr(ADDR_STACK, v & 32'h0000_1FFF);
  endtask

  task automatic run(input logic [31:0] op);
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    wr(ADDR_INSTR, op);
    n = 0;
    do begin
      axr(ADDR_CTRL, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 50);
    cmp_data(d & 32'h1, 32'h0);
  endtask

  task automatic chk;
    rd_cmp(ADDR_ACC, acc);
    rd_cmp(ADDR_STATUS, st);
    rd_cmp(ADDR_PC, pc);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [31:0] k;
    logic [31:0] a;
    logic [31:0] v;
    logic [31:0] f;
    logic [31:0] res;
    logic [1:0]  r;
    logic [7:0]  lit_t[9];
    logic [7:0]  acc_t[9];
    req = '0;
    rst = 1'b1;
    miscompares = 0;
    checked = 0;
    acc = 32'h0;
    st = 32'h18;
    pc = 32'h0;
    void'($urandom(69));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    chk();
    axr(8'h24, d, r);
    cmp_resp(r, RESP_SLVERR);
    axw(ADDR_WATCHDOG, 32'h0, r);
    cmp_resp(r, RESP_SLVERR);
    // return with literal, all literal ranges and opcode variants
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 32'h00 : (i == 1) ? 32'hFF : ($urandom & 32'hFF);
      set_state($urandom, $urandom);
      push($urandom);
      run(32'h3400 | (i << 8) | k);
      acc = k;
      pc = stk.pop_back();
      chk();
    end
    // plain return pops in order
    set_state($urandom, $urandom);
    push($urandom);
    push($urandom);
    run(32'h0008);
    pc = stk.pop_back();
    chk();
    rd_cmp(ADDR_STACK, stk[$]);
    run(32'h0008);
    pc = stk.pop_back();
    chk();
    // rotate right through carry, both destinations and carries
    for (int i = 0; i < 4; i++) begin
      f = (i == 3) ? 32'd127 : ($urandom % 128);
      v = $urandom & 32'hFF;
      wr(ADDR_FADDR, f);
      wr(ADDR_FDATA, v);
      set_state($urandom, ($urandom & 32'h1E) | (i >> 1));
      run(32'h0C00 | ((i & 1) << DEST_BIT) | f);
      res = (st[0] << 7) | (v >> 1);
      st = (st & 32'h1E) | (v & 32'h1);
      pc = (pc + 1) & 32'h1FFF;
      if (i[0]) v = res;
      else acc = res;
      chk();
      rd_cmp(ADDR_FDATA, v);
    end
    // literal subtract then literal xor, boundary operands
    lit_t = '{8'h00, 8'hFF, 8'h10, 8'h05, 8'h03, 8'h00, 8'hFF, 8'h00, 8'h00};
    acc_t = '{8'h00, 8'h01, 8'h01, 8'h05, 8'hFF, 8'h00, 8'hFF, 8'h5A, 8'h00};
    lit_t[5] = 8'($urandom);
    acc_t[5] = 8'($urandom);
    lit_t[8] = 8'($urandom);
    acc_t[8] = 8'($urandom);
    for (int i = 0; i < 9; i++) begin
      k = {24'h0, lit_t[i]};
      a = {24'h0, acc_t[i]};
      set_state(a, $urandom);
      pc = (pc + 1) & 32'h1FFF;
      if (i < 6) begin
        run(32'h3C00 | ((i & 1) << 8) | k);
        res = (k - a) & 32'hFF;
        st = (st & 32'h18) | (k >= a) | (((k & 32'hF) >= (a & 32'hF)) << 1) | ((res == 0) << 2);
      end else begin
        run(32'h3A00 | k);
        res = k ^ a;
        st = (st & 32'h1B) | ((res == 0) << 2);
      end
      acc = res;
      chk();
    end
    // halt after the watchdog has advanced
    set_state($urandom, ($urandom & 32'h7) | 32'h8);
    repeat (300) @(posedge clk);
    axr(ADDR_WATCHDOG, d, r);
    cmp_data({31'h0, d != 32'h0}, 32'h1);
    wr(ADDR_INSTR, 32'h0063);
    rd_cmp(ADDR_WATCHDOG, 32'h0);
    rd_cmp(ADDR_STATUS, (st & 32'h7) | 32'h10);
    rd_cmp(ADDR_CTRL, 32'h3);
    cmp_data({31'h0, osc_stopped}, 32'h1);
    axw(ADDR_INSTR, 32'h3A55, r);
    cmp_resp(r, RESP_SLVERR);
    repeat (300) @(posedge clk);
    rd_cmp(ADDR_WATCHDOG, 32'h0);
    rd_cmp(ADDR_ACC, acc);
    wr(ADDR_CTRL, 32'h1);
    cmp_data({31'h0, osc_stopped}, 32'h0);
    rd_cmp(ADDR_CTRL, 32'h0);
    complete_run();
  end

endmodule
